// >>> include/lsc_params.svh
// Register offsets, field positions and reset values of the display control
`ifndef LSC_PARAMS_SVH
`define LSC_PARAMS_SVH
`define LSC_OFF_CTRL0     8'h00
`define LSC_OFF_CTRL1     8'h04
`define LSC_OFF_SUPPLY    8'h08
`define LSC_OFF_REGCTL    8'h0C
`define LSC_OFF_BLINK     8'h10
`define LSC_OFF_STATUS    8'h14
`define LSC_OFF_PIN0      8'h20
`define LSC_OFF_BP0       8'h40
`define LSC_OFF_WF0       8'h80
`define LSC_BANK_PIN      3'h1
`define LSC_BANK_BP       3'h2
`define LSC_BANK_WF       3'h4
`define LSC_RST_CTRL0     8'h03
`define LSC_RST_CTRL1     8'h00
`define LSC_RST_SUPPLY    8'h83
`define LSC_RST_REGCTL    8'h00
`define LSC_RST_BLINK     8'h00
`define LSC_DUTY_QUARTER  3'h3
`define LSC_SEL_CORE_MID  2'h0
`define LSC_SEL_CORE_TOP  2'h1
`define LSC_SEL_EXT_PIN   2'h2
`define LSC_SEL_EXT_TOP   2'h3
`define LSC_FLAG_BIT      7
`define LSC_ZERO_BYTE     8'h00
`define LSC_ZERO_WORD     32'h0000_0000
`endif

// >>> include/lsc_pkg.sv
// Types shared by the display supply control logic
package lsc_pkg;
  typedef struct packed {
    logic       supply_switch_a;
    logic       supply_switch_b;
    logic       supply_switch_c;
    logic       divider_buffer_on;
    logic       ref_level_select;
    logic       divider_full_scale;
    logic       regulator_to_low;
    logic       charge_pump_on;
    logic [3:0] regulator_trim;
  } lsc_power_s;
  typedef struct packed {
    logic       display_on;
    logic [2:0] duty;
    logic [2:0] frame_clock_prescale;
    logic       alternate_display;
    logic       blank;
    logic       blink_kind;
    logic [2:0] blink_rate;
    logic       wait_mode_off;
    logic       stop_mode_off;
  } lsc_disp_s;
endpackage : lsc_pkg

// >>> logic/lsc_ctrl.sv
// Supply selection, reset defaults and frame flag of a segment display driver
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
// Overview of operation
// - Select 10: only switch c asserted
// - Low level from ref, skip, switch c
// - Ref clear: two thirds; set with switch c: full input
// - Select 11: all switches deasserted
// - Buffer on when skip clear, switch c
// - Regulator drives low level when enabled
// - Ref select picks low or high level
// - Trim steps reference, limited range
// - Select 00 mid, 01 top from core
// - Reset clears display enable; pin and backplane bits keep their value
// - Reset restores duty, bias, supply fields
// - Frame event sets sticky flag
// - Write one clears flag, zero keeps
// - Interrupt when flag and enable set
// - 64 pin and 64 backplane enable bits
// - Blink register fields; three-bit rate fields
// - Skip zero buffered with switch c, one unbuffered
`include "lsc_params.svh"
module lsc_ctrl (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [7:0]           adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic      [31:0]          dat_o,
  output logic                      ack_o,
  input  wire logic                 frame_event_i,
  output lsc_pkg::lsc_power_s       power_o,
  output lsc_pkg::lsc_disp_s        disp_o,
  output logic      [63:0]          pin_on_bits_o,
  output logic      [63:0]          backplane_select_bits_o,
  output logic                      display_irq_o
);
  import lsc_pkg::*;

  logic [7:0]  ctrl0_r;
  logic [7:0]  ctrl1_r;
  logic [7:0]  supply_r;
  logic [7:0]  regctl_r;
  logic [7:0]  blink_r;
  logic        frame_flag_r;
  logic [63:0] pin_on_bits_r;
  logic [63:0] backplane_select_bits_r;
  logic [7:0]  waveform_regs [0:63];
  logic        ack_r;
  logic [31:0] dat_r;

  // Bus decode
  wire       req        = cyc_i & stb_i & ~ack_r;
  wire       wr         = req & we_i & sel_i[0];
  wire [7:0] wbyte      = dat_i[7:0];
  wire [2:0] bank       = adr_i[7:5];
  wire [2:0] idx8       = adr_i[4:2];
  wire [5:0] wf_idx     = adr_i[7:2] - 6'(`LSC_OFF_WF0 >> 2);
  wire       in_pin     = (bank == `LSC_BANK_PIN);
  wire       in_bp      = (bank == `LSC_BANK_BP);
  wire       in_wf      = adr_i[7];
  wire       hit_ctrl0  = (adr_i == `LSC_OFF_CTRL0);
  wire       hit_ctrl1  = (adr_i == `LSC_OFF_CTRL1);
  wire       hit_supply = (adr_i == `LSC_OFF_SUPPLY);
  wire       hit_regctl = (adr_i == `LSC_OFF_REGCTL);
  wire       hit_blink  = (adr_i == `LSC_OFF_BLINK);
  wire       hit_status = (adr_i == `LSC_OFF_STATUS);

  function automatic logic [63:0] put_byte(input logic [63:0] v,
                                           input logic [2:0]  i,
                                           input logic [7:0]  b);
    logic [63:0] r;
    r = v;
    r[{i, 3'h0} +: 8] = b;
    return r;
  endfunction : put_byte

  // Field views of the control registers
  wire [1:0] bias_source_select  = supply_r[1:0];
  wire       divider_buffer_skip = supply_r[2];
  wire       ref_level_select    = supply_r[3];
  wire       charge_pump_on      = supply_r[7];
  wire       regulator_on        = regctl_r[7];
  wire [3:0] regulator_trim      = regctl_r[3:0];

  // Power switch decode from registered fields
  wire sw_a = (bias_source_select == `LSC_SEL_CORE_MID);
  wire sw_b = (bias_source_select == `LSC_SEL_CORE_TOP);
  wire sw_c = (bias_source_select == `LSC_SEL_EXT_PIN);
  wire buf_on = ~divider_buffer_skip & sw_c;

  always_comb begin
    power_o.supply_switch_a    = sw_a;
    power_o.supply_switch_b    = sw_b;
    power_o.supply_switch_c    = sw_c;
    power_o.divider_buffer_on  = buf_on;
    power_o.ref_level_select   = ref_level_select;
    // Full scale when ref set and switch c asserted; two thirds otherwise
    power_o.divider_full_scale = sw_c & ref_level_select;
    power_o.regulator_to_low   = regulator_on;
    power_o.charge_pump_on     = charge_pump_on;
    power_o.regulator_trim     = regulator_trim;
  end

  always_comb begin
    disp_o.display_on           = ctrl0_r[7];
    disp_o.duty                 = ctrl0_r[2:0];
    disp_o.frame_clock_prescale = ctrl0_r[5:3];
    disp_o.alternate_display    = blink_r[6];
    disp_o.blank                = blink_r[5];
    disp_o.blink_kind           = blink_r[3];
    disp_o.blink_rate           = blink_r[2:0];
    disp_o.wait_mode_off        = ctrl1_r[1];
    disp_o.stop_mode_off        = ctrl1_r[0];
  end

  assign pin_on_bits_o           = pin_on_bits_r;
  assign backplane_select_bits_o = backplane_select_bits_r;
  assign display_irq_o = frame_flag_r & ctrl1_r[7];

  // Flag: event wins over a simultaneous clear
  wire clr_flag = wr & hit_status & wbyte[`LSC_FLAG_BIT];
  wire flag_nxt = frame_event_i | (frame_flag_r & ~clr_flag);

  // Read mux
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = `LSC_ZERO_BYTE;
    if (hit_ctrl0)       rd_byte = ctrl0_r;
    else if (hit_ctrl1)  rd_byte = ctrl1_r;
    else if (hit_supply) rd_byte = supply_r;
    else if (hit_regctl) rd_byte = regctl_r;
    else if (hit_blink)  rd_byte = blink_r;
    else if (hit_status) rd_byte = {frame_flag_r, 7'h00};
    else if (in_pin)     rd_byte = pin_on_bits_r[{idx8, 3'h0} +: 8];
    else if (in_bp)      rd_byte = backplane_select_bits_r[{idx8, 3'h0} +: 8];
    else if (in_wf)      rd_byte = waveform_regs[wf_idx];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl0_r      <= `LSC_RST_CTRL0;
      ctrl1_r      <= `LSC_RST_CTRL1;
      supply_r     <= `LSC_RST_SUPPLY;
      regctl_r     <= `LSC_RST_REGCTL;
      blink_r      <= `LSC_RST_BLINK;
      frame_flag_r <= 1'b0;
      ack_r        <= 1'b0;
      dat_r        <= `LSC_ZERO_WORD;
    end else begin
      ack_r        <= req;
      frame_flag_r <= flag_nxt;
      if (req) dat_r <= {24'h00_0000, rd_byte};
      if (wr && hit_ctrl0)  ctrl0_r  <= wbyte;
      if (wr && hit_ctrl1)  ctrl1_r  <= wbyte;
      if (wr && hit_supply) supply_r <= wbyte;
      if (wr && hit_regctl) regctl_r <= wbyte;
      if (wr && hit_blink)  blink_r  <= wbyte;
    end
  end

  // Pin, backplane and waveform storage has no reset
  always_ff @(posedge clk_i) begin
    if (wr && in_pin)
      pin_on_bits_r <= put_byte(pin_on_bits_r, idx8, wbyte);
    if (wr && in_bp)
      backplane_select_bits_r <= put_byte(backplane_select_bits_r, idx8, wbyte);
    if (wr && in_wf)
      waveform_regs[wf_idx] <= wbyte;
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;
endmodule : lsc_ctrl

// >>> dv/lsc_ctrl_props.sv
// Port checker for the display supply control
`timescale 1ns/10ps
module lsc_ctrl_props (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                cyc_i,
  input wire logic                stb_i,
  input wire logic                we_i,
  input wire logic                ack_o,
  input wire lsc_pkg::lsc_power_s power_o,
  input wire lsc_pkg::lsc_disp_s  disp_o,
  input wire logic                display_irq_o
);
  import lsc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s; cyc_i && stb_i && !ack_o; endsequence
  sequence ack_s; ack_o ##1 !ack_o; endsequence
  wb_ack_a: assert property (req_s |=> ack_s) else $error("ack");
  only_c_a: assert property (power_o.supply_switch_c |->
    !(power_o.supply_switch_a || power_o.supply_switch_b)) else $error("c");
  one_sw_a: assert property ($onehot0(power_o[11:9])) else $error("sw");
  buf_on_a: assert property (power_o.divider_buffer_on |->
    power_o.supply_switch_c) else $error("buf");
  full_a: assert property (power_o.divider_full_scale ==
    (power_o.supply_switch_c && power_o.ref_level_select)) else $error("fs");
  wr_only_a: assert property ($changed(power_o) |->
    ack_o && $past(we_i)) else $error("chg");
  irq_hold_a: assert property (display_irq_o && !(cyc_i && we_i)
    |=> display_irq_o) else $error("irq");
  rst_def_a: assert property (disable iff (1'b0) rst_i |=>
    !disp_o.display_on && disp_o.duty == 3'h3 && !display_irq_o
    && power_o[11:9] == 3'h0) else $error("rst");
endmodule : lsc_ctrl_props
bind lsc_ctrl lsc_ctrl_props lsc_ctrl_props_i (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o),
  .power_o(power_o), .disp_o(disp_o), .display_irq_o(display_irq_o));

// >>> dv/lsc_glass_model.sv
// Glass side model giving one frame event per request
`timescale 1ns/10ps
module lsc_glass_model (
  input  wire logic clk_i,
  input  wire logic fire_i,
  output logic      frame_event_o
);
  initial frame_event_o = 1'b0;
  always @(posedge clk_i) frame_event_o <= fire_i && !frame_event_o;
endmodule : lsc_glass_model

// >>> dv/lsc_ctrl_bench.sv
// Self-checking bench for the display supply control
`timescale 1ns/10ps
module lsc_ctrl_bench;
  import lsc_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, fire = 0, ack, irq, ev;
  logic [7:0]  adr = 8'h00, q;
  logic [31:0] dat = 32'h0, rdat, seed = 32'h9aa7, r;
  logic [63:0] pins, bps;
  lsc_power_s  pw;
  lsc_disp_s   ds;
  int errors = 0, n_checks = 0;
  always #2.5 clk_i = ~clk_i;
  lsc_glass_model lsc_glass_model_i (.clk_i(clk_i), .fire_i(fire),
    .frame_event_o(ev));
  lsc_ctrl lsc_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(dat),
    .dat_o(rdat), .ack_o(ack), .frame_event_i(ev), .power_o(pw),
    .disp_o(ds), .pin_on_bits_o(pins), .backplane_select_bits_o(bps),
    .display_irq_o(irq));
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wb(logic w, logic [7:0] a, logic [7:0] d);
    int n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (ack !== 1'b1) errors++;
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  function automatic logic [5:0] exp_pw(logic [1:0] s, logic rf, logic sk);
    logic c = (s == 2'h2);
    return {s == 2'h0, s == 2'h1, c, c & !sk, rf, c & rf};
  endfunction : exp_pw
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  initial begin
    repeat (3000) @(posedge clk_i);
    errors++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 8'h08, 8'h00);
    chk("supply", {q, pw[11:8]}, 12'h830);
    chk("upper lanes", rdat[31:8], 24'h00_0000);
    wb(0, 8'h00, 8'h00);
    chk("ctrl0", {q, ds.display_on, ds.duty}, 12'h033);
    $display("reset test done");
    r = $random(seed);
    wb(1, 8'h0C, {1'b1, 3'h0, r[3:0]});
    chk("regulator", {pw.regulator_to_low, pw.regulator_trim}, {1'b1, r[3:0]});
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      wb(1, 8'h08, {1'b1, 3'h0, r[1:0], k[1:0]});
      chk("power", pw[11:6], exp_pw(k[1:0], r[1], r[0]));
    end
    $display("supply test done");
    wb(1, 8'h04, 8'h80);
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (2) @(posedge clk_i);
    wb(1, 8'h14, 8'h00);
    wb(0, 8'h14, 8'h00);
    chk("flag", {irq, q}, 9'h180);
    wb(1, 8'h14, 8'h80);
    wb(0, 8'h14, 8'h00);
    chk("flag clear", {irq, q}, 9'h000);
    $display("flag test done");
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      wb(1, 8'h20 + 8'(4 * k), r[7:0]);
      wb(1, 8'h40 + 8'(4 * k), r[15:8]);
      chk("pins", {bps[8*k+:8], pins[8*k+:8]}, r[15:0]);
    end
    wb(1, 8'h10, 8'h6F);
    chk("blink", {ds.alternate_display, ds.blank, ds.blink_kind, ds.blink_rate}, 6'h3F);
    wb(1, 8'h00, 8'h83);
    chk("display on", ds.display_on, 1'b1);
    $display("register test done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 8'h00, 8'h00);
    chk("ctrl0 again", {q, ds.display_on, ds.duty}, 12'h033);
    wb(0, 8'h08, 8'h00);
    chk("supply again", {q, pw[11:8]}, 12'h830);
    $display("second reset test done");
    close_out();
  end
endmodule : lsc_ctrl_bench
